// >>> rtl/kfsd_keyer.sv
`timescale 1ns/10ps
// Behaviour
// RL1 - Key cuts a hole in background; fill goes into the hole.
// RL2 - Shaping multiplies fill by the same key cutting the hole.
// RL3 - Unshaping divides shaped video by its key.
// RL4 - Each video input holds its own shaped/unshaped setting.
// RL5 - Setting follows the input mapped to the preset bus crosspoint being keyed.
// RL6 - Shaped input bypasses the shaping multiplier.
// RL7 - Shaped fill is added directly to the holed background.
// RL8 - Unshaped input enables shaping before the add.
// RL9 - Setting applied literally; shaped fill marked unshaped is multiplied twice.
// RL10 - Outputs carry selectable unshaping stages dividing fill by key.
// RL11 - Operator picks unshaped for non-shaped sources and normal keys.
// RL12 - Shaped setting only for sources that truly output shaped fill.
// RL13 - Shaped fill source keeps fill time-aligned with its key.
// RL14 - Output format setting switches that output's unshaper on or off.
// RL15 - Composite = bg*(1-key) + fill term, fill term optionally key-shaped.
module kfsd_keyer
    import kfsd_pkg::*;
#(
    parameter int VW = VID_W,
    parameter int KW = KEY_W,
    parameter int NIN = NUM_IN,
    parameter int NOUT = NUM_OUT
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Per-input format configuration (1 = unshaped)
    input wire logic cfgWrite,
    input wire logic [$clog2(NIN)-1:0] cfgInput,
    input wire logic cfgUnshaped,
    // Preset bus crosspoint selection of the keyed source
    input wire logic [$clog2(NIN)-1:0] presetBusSel,
    // Per-output format select (1 = unshaped)
    input wire logic [NOUT-1:0] outputFillFormatSelect,
    // Video samples
    input wire logic inValid,
    input wire logic [VW-1:0] fillIn,
    input wire logic [KW-1:0] keyIn,
    input wire logic [VW-1:0] bgIn,
    // Composite
    output logic compValid,
    output logic [VW-1:0] compOut,
    output logic [KW-1:0] compKey,
    // Output bus fills after unshaping
    output logic [NOUT-1:0] outValid,
    output logic [NOUT*VW-1:0] outFill,
    output logic [NOUT*KW-1:0] outKey,
    // Setting in effect for the current keyed source
    output logic activeUnshaped
);
    ////////////////////////////////////////////////////////////////////////
    // Elaboration checks
    // The full-scale key is a package constant, so the key width cannot float on its own
    if (KW != KEY_W) begin : g_bad_key_width
        $error("kfsd_keyer: key width differs from the full-scale key width");
    end
    // Normalisation below relies on full scale being all ones
    if (KEY_FULL != {KEY_W{1'b1}}) begin : g_bad_key_full
        $error("kfsd_keyer: full-scale key must be all ones");
    end
    if (VW < 2 || KW < 2) begin : g_bad_width
        $error("kfsd_keyer: sample and key widths must be at least two bits");
    end
    // Two folding steps only cover a sum no wider than twice the key width plus one
    if (VW > KW) begin : g_bad_ratio
        $error("kfsd_keyer: sample width may not exceed key width");
    end
    if (NIN < 2) begin : g_bad_inputs
        $error("kfsd_keyer: at least two video inputs are needed");
    end
    if (NOUT < 1) begin : g_bad_outputs
        $error("kfsd_keyer: at least one output bus is needed");
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-input format table
    localparam int SELW = $clog2(NIN);
    logic inFmt_q [NIN];
    logic [NIN-1:0] cfgHit;

    // One write enable per entry; an index past the table writes nothing
    always_comb begin
        cfgHit = '0;
        for (int k = 0; k < NIN; k++) begin
            cfgHit[k] = cfgWrite && (cfgInput == SELW'(k));
        end
    end

    for (genvar k = 0; k < NIN; k++) begin : g_fmt
        always_ff @(posedge clk) begin
            if (srst) begin
                inFmt_q[k] <= IN_FMT_RST;
            end else if (cfgHit[k]) begin
                inFmt_q[k] <= cfgUnshaped; // see RL4
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Setting of the keyed source
    logic shapeEn;

    // Looked up per sample, so a crosspoint change acts on the sample presented in the same cycle
    always_comb begin
        shapeEn = IN_FMT_RST;
        for (int k = 0; k < NIN; k++) begin
            if (presetBusSel == SELW'(k)) begin
                shapeEn = inFmt_q[k]; // see RL5
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            activeUnshaped <= IN_FMT_RST;
        end else begin
            activeUnshaped <= shapeEn;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mix stage 1: products
    localparam int PW = VW + KW;
    logic s1Valid_q;
    logic [PW-1:0] bgProd_q;
    logic [PW-1:0] fillProd_q;
    logic [KW-1:0] s1Key_q;
    logic [KW-1:0] holeGain;
    logic [KW-1:0] fillGain;

    // Background keeps the complement of the key: the hole
    assign holeGain = KEY_FULL - keyIn; // see RL1
    // Shaping is a gain of key; a shaped input takes unity gain and skips it
    assign fillGain = shapeEn ? keyIn : KEY_FULL; // see RL2 see RL6 see RL8

    always_ff @(posedge clk) begin
        if (srst) begin
            s1Valid_q <= 1'b0;
        end else begin
            s1Valid_q <= inValid;
        end
    end

    // Fill and key are sampled together; the source must keep them aligned
    always_ff @(posedge clk) begin
        s1Key_q <= keyIn; // see RL13
    end

    always_ff @(posedge clk) begin
        bgProd_q <= PW'(bgIn) * PW'(holeGain); // see RL1
    end

    // Applied even if the fill was already shaped: the setting is obeyed literally
    always_ff @(posedge clk) begin
        fillProd_q <= PW'(fillIn) * PW'(fillGain); // see RL9
    end

    ////////////////////////////////////////////////////////////////////////
    // Mix stage 2: sum and normalise to full-scale key
    localparam int QW = PW + 1 - KW;
    logic [PW:0] sum;
    logic [QW-1:0] quoHi;
    logic [KW+1:0] remHi;
    logic [1:0] quoLo;
    logic [KW:0] remLo;
    logic roundUp;
    logic [PW:0] scaled;
    logic [VW-1:0] clipped;

    assign sum = (PW+1)'(bgProd_q) + (PW+1)'(fillProd_q); // see RL7 see RL15

    // Exact floor of sum over full scale without a divider: full scale is one below a power
    // of two, so folding the high part back into the remainder twice leaves one last step
    assign quoHi = sum[PW:KW];
    assign remHi = (KW+2)'(sum[KW-1:0]) + (KW+2)'(quoHi);
    assign quoLo = remHi[KW+1:KW];
    assign remLo = (KW+1)'(remHi[KW-1:0]) + (KW+1)'(quoLo);
    assign roundUp = (remLo >= (KW+1)'(KEY_FULL));
    assign scaled = (PW+1)'(quoHi) + (PW+1)'(quoLo) + (PW+1)'(roundUp);

    // Unshaped fill over a shaped edge can exceed white: clip
    always_comb begin
        if (scaled > (PW+1)'({VW{1'b1}})) begin
            clipped = '1;
        end else begin
            clipped = VW'(scaled);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            compValid <= 1'b0;
        end else begin
            compValid <= s1Valid_q;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            compOut <= '0;
            compKey <= '0;
        end else begin
            compOut <= clipped; // see RL1
            compKey <= s1Key_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output unshapers, one per output bus
    for (genvar o = 0; o < NOUT; o++) begin : g_out
        kfsd_unshape_if #(.VW(VW), .KW(KW)) ush();
        assign ush.inValid = compValid;
        assign ush.enable = outputFillFormatSelect[o]; // see RL14
        assign ush.inFill = compOut;
        assign ush.inKey = compKey;
        kfsd_unshaper #(.VW(VW), .KW(KW)) u_ush (
            .clk(clk),
            .srst(srst),
            .u(ush.stage)
        ); // see RL10
        assign outValid[o] = ush.outValid;
        assign outFill[o*VW +: VW] = ush.outFill;
        assign outKey[o*KW +: KW] = ush.outKey;
    end
endmodule : kfsd_keyer

// >>> rtl/kfsd_pkg.sv
package kfsd_pkg;
    // Sample and key widths
    localparam int VID_W = 10;
    localparam int KEY_W = 10;
    localparam int NUM_IN = 8;
    localparam int NUM_OUT = 4;
    // Full-scale key (unity gain)
    localparam logic [KEY_W-1:0] KEY_FULL = 10'h3ff;
    // Pipeline depths
    localparam int MIX_LAT = 2;
    localparam int DIV_LAT = VID_W;
    // Reset values of per-input and per-output format settings (1 = unshaped)
    localparam logic IN_FMT_RST = 1'b1;
    localparam logic OUT_FMT_RST = 1'b0;
    typedef enum logic {KFSD_SHAPED, KFSD_UNSHAPED} kfsd_fmt_t;
endpackage : kfsd_pkg

// >>> rtl/kfsd_unshape_if.sv
`timescale 1ns/10ps
interface kfsd_unshape_if #(parameter int VW = 10, parameter int KW = 10);
    logic inValid;
    logic enable;
    logic [VW-1:0] inFill;
    logic [KW-1:0] inKey;
    logic outValid;
    logic [VW-1:0] outFill;
    logic [KW-1:0] outKey;
    modport drv (output inValid, enable, inFill, inKey, input outValid, outFill, outKey);
    modport stage (input inValid, enable, inFill, inKey, output outValid, outFill, outKey);
endinterface : kfsd_unshape_if

// >>> rtl/kfsd_unshaper.sv
`timescale 1ns/10ps
module kfsd_unshaper
    import kfsd_pkg::*;
#(
    parameter int VW = VID_W,
    parameter int KW = KEY_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Stage data
    kfsd_unshape_if.stage u
);
    // Restoring divider, one quotient bit per stage; fill*full/key, clipped
    localparam int NW = VW + KW;
    // Unpacked so that every stage flop has a process of its own as sole driver
    logic vld [VW+1];
    logic en [VW+1];
    logic [NW-1:0] rem [VW+1];
    logic [VW-1:0] quo [VW+1];
    logic [KW-1:0] key [VW+1];
    logic [VW-1:0] raw [VW+1];

    always_comb begin
        rem[0] = NW'(u.inFill) * NW'(KEY_FULL);
        quo[0] = '0;
        key[0] = u.inKey;
        raw[0] = u.inFill;
        vld[0] = u.inValid;
        en[0] = u.enable;
    end

    for (genvar i = 0; i < VW; i++) begin : g_div
        localparam int SH = VW - 1 - i;
        logic [NW+VW-1:0] trial;
        logic fits;
        assign trial = (NW+VW)'(key[i]) << SH;
        assign fits = ((NW+VW)'(rem[i]) >= trial);
        always_ff @(posedge clk) begin
            if (srst) begin
                vld[i+1] <= 1'b0;
            end else begin
                vld[i+1] <= vld[i];
            end
        end
        always_ff @(posedge clk) begin
            en[i+1] <= en[i];
            key[i+1] <= key[i];
            raw[i+1] <= raw[i];
            rem[i+1] <= fits ? NW'((NW+VW)'(rem[i]) - trial) : rem[i];
            quo[i+1] <= {quo[i][VW-2:0], fits};
        end
    end

    logic [NW-1:0] leftover;
    logic clip;
    assign leftover = rem[VW];
    // Zero or tiny key overflows the quotient; saturate instead of wrapping
    assign clip = (key[VW] == '0) || (leftover >= NW'(key[VW]));

    always_ff @(posedge clk) begin
        if (srst) begin
            u.outValid <= 1'b0;
            u.outFill <= '0;
            u.outKey <= '0;
        end else begin
            u.outValid <= vld[VW];
            u.outKey <= key[VW];
            if (!en[VW]) begin
                u.outFill <= raw[VW]; // see RL14
            end else if (clip) begin
                u.outFill <= '1;
            end else begin
                u.outFill <= quo[VW]; // see RL3
            end
        end
    end
endmodule : kfsd_unshaper

// >>> tb/kfsd_keyer_asserts.sv
`timescale 1ns/10ps
module kfsd_keyer_asserts
    import kfsd_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Samples and settings
    input wire logic inValid,
    input wire logic [VID_W-1:0] fillIn,
    input wire logic [KEY_W-1:0] keyIn,
    input wire logic [VID_W-1:0] bgIn,
    input wire logic [NUM_OUT-1:0] outputFillFormatSelect,
    // Results
    input wire logic compValid,
    input wire logic [VID_W-1:0] compOut,
    input wire logic [KEY_W-1:0] compKey,
    input wire logic [NUM_OUT-1:0] outValid,
    input wire logic [NUM_OUT*VID_W-1:0] outFill,
    input wire logic [NUM_OUT*KEY_W-1:0] outKey,
    input wire logic activeUnshaped
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    chk_comp_valid: assert property (compValid == $past(inValid, 2))
        else $error("composite valid misaligned");
    chk_comp_key: assert property (compValid |-> compKey == $past(keyIn, 2))
        else $error("composite key misaligned");
    chk_full_key: assert property (inValid && keyIn == KEY_FULL |-> ##2 compOut == $past(fillIn, 2))
        else $error("full key does not pass fill");
    chk_hole_cut: assert property (inValid && keyIn == 10'h000 && fillIn == 10'h000 |-> ##2 compOut == $past(bgIn, 2))
        else $error("zero key does not pass background");
    chk_out_valid: assert property (outValid == {NUM_OUT{$past(compValid, 11)}})
        else $error("output valid misaligned");
    chk_out_key: assert property (outValid[0] |-> outKey[KEY_W-1:0] == $past(compKey, 11))
        else $error("output key misaligned");
    chk_out_pass: assert property (outValid[0] && !$past(outputFillFormatSelect[0], 11)
        |-> outFill[VID_W-1:0] == $past(compOut, 11))
        else $error("shaped output not passed");
    chk_unshape_zero: assert property (outValid[0] && $past(outputFillFormatSelect[0], 11)
        && $past(compKey, 11) == 10'h000 |-> outFill[VID_W-1:0] == 10'h3ff)
        else $error("zero key divide not saturated");
    chk_reset_table: assert property ($fell(srst) |-> activeUnshaped)
        else $error("input setting not unshaped after reset");
endmodule : kfsd_keyer_asserts

bind kfsd_keyer kfsd_keyer_asserts u_kfsd_keyer_asserts (.clk(clk), .srst(srst), .inValid(inValid),
    .fillIn(fillIn), .keyIn(keyIn), .bgIn(bgIn), .outputFillFormatSelect(outputFillFormatSelect),
    .compValid(compValid), .compOut(compOut), .compKey(compKey), .outValid(outValid), .outFill(outFill),
    .outKey(outKey), .activeUnshaped(activeUnshaped));

// >>> tb/kfsd_video_src.sv
`timescale 1ns/10ps
module kfsd_video_src
    import kfsd_pkg::*;
(
    // Clock and control
    input wire logic clk,
    input wire logic en,
    input wire logic shapedSrc,
    // Key and fill pair
    output logic inValid,
    output logic [VID_W-1:0] fillIn,
    output logic [KEY_W-1:0] keyIn,
    output logic [VID_W-1:0] bgIn
);
    int seed = 32'he941b48b;
    int n = 0;
    logic g, s;
    logic [VID_W-1:0] f;
    initial {inValid, fillIn, keyIn, bgIn} = '0;
    always @(posedge clk) begin
        g = en;
        s = shapedSrc;
        #1;
        if (g) begin
            keyIn = (n % 4 == 0) ? KEY_FULL : (n % 4 == 1) ? 10'h000 : KEY_W'($random(seed));
            f = (n % 4 == 1) ? 10'h000 : VID_W'($random(seed));
            // Shaped fill is built from the very key it travels with
            fillIn = s ? VID_W'((f * keyIn) / 32'h3ff) : f;
            bgIn = VID_W'($random(seed));
            n++;
        end else begin
            // Idle lines invert every bit of the previous sample each cycle
            {fillIn, keyIn, bgIn} = ~{fillIn, keyIn, bgIn};
        end
        inValid = g;
    end
endmodule : kfsd_video_src

// >>> tb/kfsd_keyer_test.sv
`timescale 1ns/10ps
module kfsd_keyer_test import kfsd_pkg::*;;
    logic clk, srst, cfgWrite, cfgUnshaped, en, shapedSrc, inValid, compValid, activeUnshaped, act = 1'b1;
    logic [2:0] cfgInput, presetBusSel;
    logic [NUM_OUT-1:0] fmt, outValid;
    logic [VID_W-1:0] fillIn, bgIn, compOut;
    logic [KEY_W-1:0] keyIn, compKey;
    logic [NUM_OUT*VID_W-1:0] outFill;
    logic [NUM_OUT*KEY_W-1:0] outKey;
    logic tbl [NUM_IN] = '{default: 1'b1};
    logic [19:0] cq[$], oq[$], w;
    int mismatches = 0, cmp_count = 0, seed = 32'he941b48b, i, p;
    kfsd_video_src u_kfsd_video_src (.clk(clk), .en(en), .shapedSrc(shapedSrc), .inValid(inValid),
        .fillIn(fillIn), .keyIn(keyIn), .bgIn(bgIn));
    kfsd_keyer u_kfsd_keyer (.clk(clk), .srst(srst), .cfgWrite(cfgWrite), .cfgInput(cfgInput),
        .cfgUnshaped(cfgUnshaped), .presetBusSel(presetBusSel), .outputFillFormatSelect(fmt),
        .inValid(inValid), .fillIn(fillIn), .keyIn(keyIn), .bgIn(bgIn), .compValid(compValid),
        .compOut(compOut), .compKey(compKey), .outValid(outValid), .outFill(outFill), .outKey(outKey),
        .activeUnshaped(activeUnshaped));
    task automatic check(string nm, logic [19:0] seen, logic [19:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic complete_run;
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    function automatic logic [9:0] mix(logic [9:0] f, logic [9:0] k, logic [9:0] b, logic sh);
        int t;
        t = (b * (32'h3ff - k) + (sh ? f * k : f * 32'h3ff)) / 32'h3ff;
        return (t > 32'h3ff) ? 10'h3ff : 10'(t);
    endfunction : mix
    function automatic logic [9:0] uns(logic [9:0] c, logic [9:0] k, logic on);
        int t;
        t = (k == 10'h000) ? 32'h3ff : (c * 32'h3ff) / k;
        return !on ? c : (t > 32'h3ff) ? 10'h3ff : 10'(t);
    endfunction : uns
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Model reads the setting before a same-edge write lands
    always @(posedge clk) begin
        if (!srst) check("activeUnshaped", activeUnshaped, act);
        act = tbl[presetBusSel];
        if (!srst && inValid) cq.push_back({keyIn, mix(fillIn, keyIn, bgIn, tbl[presetBusSel])});
        if (cfgWrite) tbl[cfgInput] = cfgUnshaped;
        if (compValid) begin
            w = cq.pop_front();
            check("compOut", compOut, w[9:0]);
            check("compKey", compKey, w[19:10]);
            oq.push_back(w);
        end
        if (outValid[0]) begin
            w = oq.pop_front();
            check("outValid", 20'(outValid), 20'({NUM_OUT{1'b1}}));
            for (i = 0; i < NUM_OUT; i++) begin
                check("outFill", outFill[i*VID_W +: VID_W], uns(w[9:0], w[19:10], fmt[i]));
                check("outKey", outKey[i*KEY_W +: KEY_W], w[19:10]);
            end
        end
    end
    task automatic phase(logic sh, logic [3:0] f);
        @(posedge clk);
        #1 fmt = f;
        shapedSrc = sh;
        repeat (40) begin
            @(posedge clk);
            #1 en = 1'b1;
            presetBusSel = 3'($random(seed));
            cfgWrite = 1'($random(seed));
            cfgInput = 3'($random(seed));
            cfgUnshaped = 1'($random(seed));
        end
        @(posedge clk);
        #1 en = 1'b0;
        cfgWrite = 1'b0;
        // Drain the unshaper pipe before the format may change
        repeat (20) @(posedge clk);
    endtask : phase
    initial begin
        {srst, cfgWrite, cfgInput, cfgUnshaped, presetBusSel, fmt, en, shapedSrc} = {1'b1, 14'h0000};
        repeat (16) @(posedge clk);
        #1 srst = 1'b0;
        for (p = 0; p < 8; p++) phase(p[0], 4'(p * 5));
        check("pending", 20'(cq.size() + oq.size()), 20'h00000);
        complete_run();
    end
endmodule : kfsd_keyer_test
